/* File: design/nand_bus_pkg.sv */
// constants, modes and carriers for the asynchronous nand bus front end
// assumes one clock domain; bus pins arrive already synchronous to it
package nand_bus_pkg;

	localparam int ADDR_CYCLES = 5;
	localparam int CYCLE_W = 3;
	localparam int COLUMN_W = 13;
	localparam int PAGE_W = 7;
	localparam int BLOCK_W = 11;
	localparam int ROW_W = PAGE_W + BLOCK_W;
	localparam int PAGE_BITS_IN_C3 = 7;
	localparam int PLANE_BIT_POS = 7;
	localparam int COL_HI_BITS = 5;
	localparam int BLK_HI_BITS = 2;

	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_SELECT_UNIT_STATUS = 8'h78;
	localparam logic [COLUMN_W-1:0] COLUMN_LIMIT = 13'h10E0;
	localparam logic [CYCLE_W-1:0] LAST_CYCLE = 3'h4;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef enum logic [6:0] {
		MODE_STANDBY = 7'h01,
		MODE_IDLE = 7'h02,
		MODE_COMMAND = 7'h04,
		MODE_ADDRESS = 7'h08,
		MODE_DATA_IN = 7'h10,
		MODE_DATA_OUT = 7'h20,
		MODE_UNDEFINED = 7'h40
	} mode_t;

	typedef struct packed {
		logic cmd_latch;
		logic addr_latch;
		logic write_strobe_n;
		logic read_strobe_n;
		logic [7:0] io;
	} bus_in_t;

	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} cmd_t;

	typedef struct packed {
		logic [COLUMN_W-1:0] column_addr_bits;
		logic [PAGE_W-1:0] page_addr_bits;
		logic [BLOCK_W-1:0] block_bits;
		logic plane;
	} addr_t;

endpackage

/* File: design/nand_async_bus_latch.sv */
// asynchronous bus front end of one nand target: mode decode, latching,
// address split, target enable and standby.
// assumes pins are synchronous to clock; array and cache logic lie outside.
`timescale 1ns/1ns
module nand_async_bus_latch #(
	parameter int TARGET_INDEX = 0,
	parameter int UNITS = 1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic second_chip_select_n,
	input wire nand_bus_pkg::bus_in_t bus,
	input wire logic write_protect_n,
	input wire logic [UNITS-1:0] unit_busy,
	input wire logic sync_mode,
	input wire logic cache_operation,
	input wire logic cache_program_busy,
	input wire logic [7:0] cache_rd_byte,
	input wire logic [7:0] status_byte,
	output logic [7:0] io_out,
	output logic io_oe,
	output logic dqs_out,
	output logic dqs_oe,
	output logic ready_busy_out,
	output logic ready_busy_oe,
	output nand_bus_pkg::mode_t bus_mode,
	output logic standby,
	output nand_bus_pkg::cmd_t cmd,
	output logic addr_byte_valid,
	output logic addr_done,
	output nand_bus_pkg::addr_t addr,
	output logic column_oob,
	output logic [nand_bus_pkg::ROW_W-1:0] row_addr,
	output logic [nand_bus_pkg::BLOCK_W-1:0] erase_block_addr,
	output logic [nand_bus_pkg::COLUMN_W-1:0] column_addr,
	output logic data_wr_valid,
	output logic [7:0] data_wr_byte,
	output logic data_rd_next,
	output logic program_erase_allowed,
	output logic regs_combined
);

	// own select only; second select serves the second die of a package
	wire logic select_n;
	assign select_n = (TARGET_INDEX == 0) ? chip_select_n : second_chip_select_n;

	wire logic any_busy;
	assign any_busy = |unit_busy;

	// previous strobe levels for edge detection
	logic we_prev_q;
	logic re_prev_q;

	wire logic we_rise;
	wire logic re_fall;
	assign we_rise = bus.write_strobe_n & ~we_prev_q;
	assign re_fall = ~bus.read_strobe_n & re_prev_q;

	// mode decode from the pin levels
	nand_bus_pkg::mode_t mode_now;
	always_comb begin
		if (select_n) begin
			mode_now = nand_bus_pkg::MODE_STANDBY;
		end else if (bus.write_strobe_n && bus.read_strobe_n && !we_rise) begin
			mode_now = nand_bus_pkg::MODE_IDLE;
		end else if (bus.cmd_latch && bus.addr_latch) begin
			mode_now = nand_bus_pkg::MODE_UNDEFINED;
		end else if (bus.cmd_latch) begin
			mode_now = nand_bus_pkg::MODE_COMMAND;
		end else if (bus.addr_latch) begin
			mode_now = nand_bus_pkg::MODE_ADDRESS;
		end else if (!bus.read_strobe_n && bus.write_strobe_n) begin
			mode_now = nand_bus_pkg::MODE_DATA_OUT;
		end else begin
			mode_now = nand_bus_pkg::MODE_DATA_IN;
		end
	end

	// write-side strobes are valid only with read strobe high
	wire logic wr_ok;
	assign wr_ok = ~select_n & we_rise & bus.read_strobe_n;

	wire logic cmd_edge;
	wire logic addr_edge;
	wire logic data_edge;
	assign cmd_edge = wr_ok & bus.cmd_latch & ~bus.addr_latch;
	assign addr_edge = wr_ok & bus.addr_latch & ~bus.cmd_latch;
	assign data_edge = wr_ok & ~bus.cmd_latch & ~bus.addr_latch;

	wire logic status_code;
	assign status_code = (bus.io == nand_bus_pkg::CMD_READ_STATUS) ||
		(bus.io == nand_bus_pkg::CMD_SELECT_UNIT_STATUS);

	wire logic cmd_take;
	assign cmd_take = cmd_edge & (~any_busy | status_code);

	logic sel_status_q;
	logic status_read_q;

	wire logic addr_take;
	assign addr_take = addr_edge & (~any_busy | sel_status_q);

	// a busy unit still takes data during a cached program
	wire logic data_take;
	assign data_take = data_edge & (~any_busy | cache_program_busy);

	// reads from cache wait for ready; status may be read while busy
	wire logic rd_take;
	assign rd_take = ~select_n & re_fall & bus.write_strobe_n &
		~bus.cmd_latch & ~bus.addr_latch & (~any_busy | status_read_q);

	// address cycle tracking
	logic [nand_bus_pkg::CYCLE_W-1:0] cycle_q;
	logic [nand_bus_pkg::CYCLE_W-1:0] cycle_d;
	logic [7:0] byte_q [nand_bus_pkg::ADDR_CYCLES];

	wire logic last_cycle;
	assign last_cycle = (cycle_q == nand_bus_pkg::LAST_CYCLE);

	// byte view that already holds the byte being taken, so the fields
	// settle in the same cycle as addr_done instead of one cycle later
	logic [7:0] byte_v [nand_bus_pkg::ADDR_CYCLES];
	always_comb begin
		for (int i = 0; i < nand_bus_pkg::ADDR_CYCLES; i++) begin
			byte_v[i] = byte_q[i];
		end
		if (addr_take) begin
			byte_v[cycle_q] = bus.io;
		end
	end

	always_comb begin
		cycle_d = cycle_q;
		if (cmd_take) begin
			cycle_d = '0;
		end else if (addr_take) begin
			cycle_d = last_cycle ? '0 : cycle_q + 3'h1;
		end
	end

	// the unused upper bits of cycles two and five are dropped, not checked
	wire logic [nand_bus_pkg::COLUMN_W-1:0] col_raw;
	assign col_raw = {byte_v[1][nand_bus_pkg::COL_HI_BITS-1:0], byte_v[0]};

	wire logic [nand_bus_pkg::COLUMN_W-1:0] col_eff;
	assign col_eff = {col_raw[nand_bus_pkg::COLUMN_W-1:1],
		col_raw[0] & ~sync_mode};

	wire logic [nand_bus_pkg::PAGE_W-1:0] page_raw;
	assign page_raw = byte_v[2][nand_bus_pkg::PAGE_BITS_IN_C3-1:0];

	wire logic [nand_bus_pkg::BLOCK_W-1:0] block_raw;
	assign block_raw = {byte_v[4][nand_bus_pkg::BLK_HI_BITS-1:0], byte_v[3],
		byte_v[2][nand_bus_pkg::PLANE_BIT_POS]};

	wire logic plane_raw;
	assign plane_raw = byte_v[2][nand_bus_pkg::PLANE_BIT_POS];

	// registered fields and addr_done both appear one cycle after the take
	logic addr_done_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			we_prev_q <= 1'b1;
			re_prev_q <= 1'b1;
			cycle_q <= '0;
		end else begin
			we_prev_q <= bus.write_strobe_n;
			re_prev_q <= bus.read_strobe_n;
			cycle_q <= cycle_d;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < nand_bus_pkg::ADDR_CYCLES; i++) begin
				byte_q[i] <= nand_bus_pkg::BYTE_RESET;
			end
		end else if (addr_take) begin
			byte_q[cycle_q] <= bus.io;
		end
	end

	// command register and status tracking
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmd <= '0;
			sel_status_q <= 1'b0;
			status_read_q <= 1'b0;
		end else begin
			cmd.valid <= cmd_take;
			if (cmd_take) begin
				cmd.code <= bus.io;
				sel_status_q <= (bus.io == nand_bus_pkg::CMD_SELECT_UNIT_STATUS);
				status_read_q <= status_code;
			end
		end
	end

	// address outputs
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			addr_byte_valid <= 1'b0;
			addr_done_q <= 1'b0;
		end else begin
			addr_byte_valid <= addr_take;
			addr_done_q <= addr_take & last_cycle;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			addr <= '0;
			column_oob <= 1'b0;
			row_addr <= '0;
			erase_block_addr <= '0;
			column_addr <= '0;
		end else begin
			addr.column_addr_bits <= col_eff;
			addr.page_addr_bits <= page_raw;
			addr.block_bits <= block_raw;
			addr.plane <= plane_raw;
			column_oob <= (col_raw >= nand_bus_pkg::COLUMN_LIMIT);
			row_addr <= {block_raw, page_raw};
			erase_block_addr <= block_raw;
			column_addr <= col_eff;
		end
	end

	assign addr_done = addr_done_q;

	// data input to cache, one byte per strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			data_wr_valid <= 1'b0;
			data_wr_byte <= nand_bus_pkg::BYTE_RESET;
		end else begin
			data_wr_valid <= data_take;
			if (data_take) begin
				data_wr_byte <= bus.io;
			end
		end
	end

	// data output: the byte stays on the bus until the strobe rises again,
	// so a slow host may still latch on that rising edge
	wire logic out_mode;
	assign out_mode = (mode_now == nand_bus_pkg::MODE_DATA_OUT);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			io_out <= nand_bus_pkg::BYTE_RESET;
			io_oe <= 1'b0;
			data_rd_next <= 1'b0;
		end else begin
			data_rd_next <= rd_take & ~status_read_q;
			if (rd_take) begin
				io_out <= status_read_q ? status_byte : cache_rd_byte;
				io_oe <= 1'b1;
			end else if (!out_mode) begin
				io_oe <= 1'b0;
			end
		end
	end

	// target state: standby waits for every unit to finish
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus_mode <= nand_bus_pkg::MODE_STANDBY;
			standby <= 1'b0;
			ready_busy_oe <= 1'b0;
			program_erase_allowed <= 1'b0;
			regs_combined <= 1'b1;
		end else begin
			bus_mode <= mode_now;
			standby <= select_n & ~any_busy;
			ready_busy_oe <= any_busy;
			program_erase_allowed <= write_protect_n;
			regs_combined <= ~cache_operation;
		end
	end

	// open drain: only ever pulls low; the board pull-up shows ready
	assign ready_busy_out = 1'b0;

	// only the asynchronous interface exists here, so the strobe never drives
	assign dqs_out = 1'b0;
	assign dqs_oe = 1'b0;

endmodule

/* File: testbench/nand_async_bus_latch_asserts.sv */
// concurrent checks on the ports of the nand bus front end
// assumes pins are sampled on the rising clock edge, as the design does
`timescale 1ns/1ns
module nand_async_bus_latch_chk #(
	parameter int UNITS = 1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire nand_bus_pkg::bus_in_t bus,
	input wire logic write_protect_n,
	input wire logic [UNITS-1:0] unit_busy,
	input wire logic sync_mode,
	input wire logic [7:0] cache_rd_byte,
	input wire logic [7:0] status_byte,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic dqs_oe,
	input wire logic ready_busy_oe,
	input wire logic standby,
	input wire nand_bus_pkg::cmd_t cmd,
	input wire logic addr_byte_valid,
	input wire logic addr_done,
	input wire nand_bus_pkg::addr_t addr,
	input wire logic [nand_bus_pkg::COLUMN_W-1:0] column_addr,
	input wire logic data_wr_valid,
	input wire logic [7:0] data_wr_byte,
	input wire logic program_erase_allowed
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	wire busy = |unit_busy;
	wire sel = !chip_select_n && bus.read_strobe_n;
	wire no_lat = !bus.cmd_latch && !bus.addr_latch;
	wire off_idle = chip_select_n && !busy;
	wire took = cmd.valid || addr_byte_valid || data_wr_valid;
	a_cmd_take: assert property (
		$rose(bus.write_strobe_n) && sel && bus.cmd_latch && !bus.addr_latch && !busy
		|=> cmd.valid && cmd.code == $past(bus.io)) else $error("command not latched");
	a_addr_take: assert property (
		$rose(bus.write_strobe_n) && sel && bus.addr_latch && !bus.cmd_latch && !busy
		|=> addr_byte_valid) else $error("address byte not latched");
	a_data_take: assert property (
		$rose(bus.write_strobe_n) && sel && no_lat && !busy
		|=> data_wr_valid && data_wr_byte == $past(bus.io)) else $error("data byte lost");
	a_deselect_quiet: assert property (chip_select_n |=> !took)
		else $error("latched while deselected");
	a_both_latches: assert property (bus.cmd_latch && bus.addr_latch |=> !took)
		else $error("latched with both latches high");
	a_busy_cmd: assert property (
		$rose(bus.write_strobe_n) && busy && bus.io != 8'h70 && bus.io != 8'h78
		|=> !cmd.valid) else $error("busy accepted a command");
	a_read_out: assert property (
		$fell(bus.read_strobe_n) && !chip_select_n && bus.write_strobe_n && no_lat && !busy
		|=> io_oe && (io_out == $past(cache_rd_byte) || io_out == $past(status_byte)))
		else $error("read byte not driven");
	a_idle_quiet: assert property (bus.read_strobe_n |=> !io_oe)
		else $error("io driven while idle");
	a_plane_bit: assert property (addr.plane == addr.block_bits[0])
		else $error("plane does not follow block bit");
	a_sync_column: assert property (sync_mode [*2] |=> !column_addr[0])
		else $error("column bit zero not forced");
	a_standby_lag: assert property ($past(reset_n) |-> standby == $past(off_idle))
		else $error("standby wrong");
	a_protect_copy: assert property (
		$past(reset_n) |-> program_erase_allowed == $past(write_protect_n))
		else $error("protect not followed");
	a_ready_busy: assert property ($past(reset_n) |-> ready_busy_oe == $past(busy))
		else $error("ready busy wrong");
	a_strobe_off: assert property (!dqs_oe)
		else $error("data strobe driven");
	cover property (addr_done);
	cover property ($rose(io_oe));
	cover property (standby);
endmodule
bind nand_async_bus_latch nand_async_bus_latch_chk #(.UNITS(UNITS)) chk_i (.clock, .reset_n,
	.chip_select_n, .bus, .write_protect_n, .unit_busy, .sync_mode, .cache_rd_byte,
	.status_byte, .io_out, .io_oe, .dqs_oe, .ready_busy_oe, .standby, .cmd,
	.addr_byte_valid, .addr_done, .addr, .column_addr, .data_wr_valid, .data_wr_byte,
	.program_erase_allowed);

/* File: testbench/nand_host_model.sv */
// host controller model driving the multiplexed nand bus pins
// assumes tasks are entered just after a rising clock edge
`timescale 1ns/1ns
module nand_host_model (
	input wire logic clock,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	output nand_bus_pkg::bus_in_t bus
);
	initial bus = 12'h3FF;
	// strobe low for a full cycle so the edge is always seen
	task automatic wr(input logic cl, input logic al, input logic [7:0] b);
		bus = {cl, al, 2'b01, b};
		@(posedge clock) #1;
		bus.write_strobe_n = 1'b1;
		@(posedge clock) #1;
		// the byte stays until the next call sets the whole bus in one step
	endtask
	task automatic rd(output logic [7:0] q, output logic oe);
		bus = {4'h2, 8'hA5};
		@(posedge clock) #1;
		q = io_out;
		oe = io_oe;
		bus.read_strobe_n = 1'b1;
		@(posedge clock) #1;
	endtask
endmodule

/* File: testbench/test_nand_async_bus_latch.sv */
// self-checking bench for the nand bus front end: table, then directed cases
// assumes the host model owns the bus pins; cache and status bytes are fixed
`timescale 1ns/1ns
module test_nand_async_bus_latch;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic chip_select_n = 1'b0;
	logic second_chip_select_n = 1'b1;
	logic write_protect_n = 1'b1;
	logic [0:0] unit_busy = 1'h0;
	logic sync_mode = 1'b0;
	logic cache_operation = 1'b0;
	logic [7:0] q, io_out, data_wr_byte;
	logic oe, io_oe, dqs_oe, ready_busy_oe, standby, addr_byte_valid, addr_done;
	logic dqs_out, ready_busy_out, data_rd_next;
	logic [10:0] erase_block_addr;
	int n_read = 0;
	logic column_oob, data_wr_valid, program_erase_allowed, regs_combined;
	logic [17:0] row_addr;
	logic [12:0] column_addr;
	nand_bus_pkg::bus_in_t bus;
	nand_bus_pkg::mode_t bus_mode;
	nand_bus_pkg::cmd_t cmd;
	nand_bus_pkg::addr_t addr;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	// {cmd_latch, addr_latch, busy, 2'b0, cmd/addr/data expected, byte}
	logic [15:0] rows [10] = '{16'h8400, 16'hA470, 16'hA478, 16'hA080, 16'h6212,
		16'h8400, 16'h6012, 16'h2055, 16'h0155, 16'hC033};
	logic [7:0] ab [10] = '{8'hE0, 8'h10, 8'hD5, 8'hA5, 8'h03, 8'hDF, 8'h10, 8'h00, 8'h00, 8'h00};
	logic [39:0] ea [2] = '{{1'b1, 13'h10E0, 11'h74B, 7'h55, 1'b1}, {1'b0, 13'h10DF, 19'h0}};
	always #20 clock = ~clock;
	nand_host_model host (.clock, .io_out, .io_oe, .bus);
	nand_async_bus_latch uut (.clock, .reset_n, .chip_select_n, .second_chip_select_n, .bus,
		.write_protect_n, .unit_busy, .sync_mode, .cache_operation, .cache_program_busy(1'b0),
		.cache_rd_byte(8'h3C), .status_byte(8'hC7), .io_out, .io_oe, .dqs_out, .dqs_oe,
		.ready_busy_out, .ready_busy_oe, .bus_mode, .standby, .cmd, .addr_byte_valid,
		.addr_done, .addr, .column_oob, .row_addr, .erase_block_addr, .column_addr,
		.data_wr_valid, .data_wr_byte, .data_rd_next, .program_erase_allowed, .regs_combined);
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			end_sim();
		end
	end
	// cache bytes consumed, counted where the pulse has settled
	always @(negedge clock) begin
		if (data_rd_next === 1'b1) n_read++;
	end
	initial begin
		repeat (6) @(posedge clock);
		#1 reset_n = 1'b1;
		@(posedge clock) #1;
		foreach (rows[i]) begin
			unit_busy = rows[i][13];
			host.wr(rows[i][15], rows[i][14], rows[i][7:0]);
			chk({cmd.valid, addr_byte_valid, data_wr_valid}, rows[i][10:8]);
			if (rows[i][10] | rows[i][8]) chk(rows[i][10] ? cmd.code : data_wr_byte, rows[i][7:0]);
			chk(bus_mode, rows[i][15] ? (rows[i][14] ? nand_bus_pkg::MODE_UNDEFINED :
				nand_bus_pkg::MODE_COMMAND) : rows[i][14] ? nand_bus_pkg::MODE_ADDRESS :
				nand_bus_pkg::MODE_DATA_IN);
		end
		unit_busy = 1'b0;
		$display("table done");
		// second set follows without a command, so the byte count must wrap
		host.wr(1'b1, 1'b0, 8'h00);
		foreach (ab[i]) begin
			host.wr(1'b0, 1'b1, ab[i]);
			chk(addr_done, i % 5 == 4);
			if (i % 5 == 4) chk({column_oob, column_addr, row_addr, addr.plane}, ea[i / 5]);
			if (i % 5 == 4) chk(erase_block_addr, ea[i / 5][18:8]);
		end
		sync_mode = 1'b1;
		repeat (2) @(posedge clock) #1;
		chk(column_addr, 13'h10DE);
		sync_mode = 1'b0;
		$display("address done");
		host.wr(1'b1, 1'b0, 8'h00);
		host.rd(q, oe);
		chk({oe, q}, 9'h13C);
		chk(io_oe, 1'b0);
		chk(bus_mode, nand_bus_pkg::MODE_IDLE);
		unit_busy = 1'b1;
		host.rd(q, oe);
		chk(oe, 1'b0);
		host.wr(1'b1, 1'b0, 8'h70);
		host.rd(q, oe);
		chk({oe, q}, 9'h1C7);
		chk(n_read, 1);
		unit_busy = 1'b0;
		$display("read done");
		chip_select_n = 1'b1;
		second_chip_select_n = 1'b0;
		write_protect_n = 1'b0;
		cache_operation = 1'b1;
		host.wr(1'b1, 1'b0, 8'h00);
		chk({cmd.valid, standby, program_erase_allowed}, 3'h2);
		chk({regs_combined, dqs_oe, dqs_out, ready_busy_out}, 4'h0);
		chk(bus_mode, nand_bus_pkg::MODE_STANDBY);
		unit_busy = 1'b1;
		@(posedge clock) #1;
		chk({standby, ready_busy_oe}, 2'h1);
		{chip_select_n, second_chip_select_n, write_protect_n} = 3'h3;
		{unit_busy, cache_operation} = 2'h0;
		host.wr(1'b1, 1'b0, 8'h90);
		chk({cmd.valid, regs_combined}, 2'h3);
		$display("select done");
		reset_n = 1'b0;
		#1;
		chk({cmd, addr_done, io_oe, regs_combined, bus_mode}, {11'h1, nand_bus_pkg::MODE_STANDBY});
		@(posedge clock) #1 reset_n = 1'b1;
		@(posedge clock) #1;
		host.wr(1'b1, 1'b0, 8'h90);
		chk(cmd, 9'h190);
		$display("reset done");
		end_sim();
	end
endmodule
